/* File: rtl/qdsl_buf.sv */
// Purpose: two-entry valid/ready buffer for loaded words
// Assumes: same clock on both sides
// Notes:   full and empty are exact; input ready drops only when both slots hold
`timescale 1ns/1ps
`default_nettype none
module qdsl_buf
  import qdsl_pkg::*;
#(
  parameter int WIDTH = 14
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] slot_reg [BUF_DEPTH];
  logic             rd_ptr_reg;
  logic             wr_ptr_reg;
  logic [1:0]       count_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_reg != 2'd2);
  assign out_valid_o = (count_reg != 2'd0);
  assign out_data_o  = slot_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage has no reset; valid is guarded by the count
  always_ff @(posedge clk_i)
  begin
    if (push)
      slot_reg[wr_ptr_reg] <= in_data_i;
  end

  // pointers and occupancy
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg  <= 2'd0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop)
        count_reg <= count_reg + 2'd1;
      else if (pop && !push)
        count_reg <= count_reg - 2'd1;
    end
  end
endmodule : qdsl_buf
`default_nettype wire

/* File: rtl/qdsl_pkg.sv */
// Purpose: shared constants for the quad converter serial load and clear logic
// Assumes: one system clock at 250 MHz samples all device pins
// Notes:   word layout is address first, then fill, then data msb to lsb
package qdsl_pkg;
  localparam int          WORD_BITS    = 16;
  localparam int          DATA_BITS    = 12;
  localparam int          ADDR_BITS    = 2;
  localparam int          NUM_CONV     = 4;
  localparam int          ADDR_HI_POS  = 15;
  localparam int          ADDR_LO_POS  = 14;
  localparam int          DATA_MSB_POS = 11;
  localparam logic [11:0] MIDSCALE     = 12'h800;
  localparam logic [11:0] ZEROSCALE    = 12'h000;
  localparam logic [15:0] SHIFT_RESET  = 16'h0000;
  localparam logic [5:0]  SYNC_RESET   = 6'h1D;
  localparam logic [11:0] DATA_RESET   = 12'h000;
  localparam int          SYNC_STAGES  = 2;
  localparam int          BUF_DEPTH    = 2;
endpackage : qdsl_pkg

/* File: rtl/qdsl_top.sv */
// Purpose: serial word capture, load strobe and clear for four 12-bit converter registers
// Assumes: all pins except CONV_READY_I and SYS_RST_I are asynchronous to CLK_I and are synchronised by two flops
// Notes:   pin edges are seen a few system cycles late; pin widths must exceed 3 cycles
// Overview of operation
// - select low: shift data on clock rise
// - 16-bit word, upper address bit first
// - select high: serial data ignored
// - shift clock is clock OR select
// - load low copies word, ignoring select
// - clear forces midscale or zero per select
// - clear leaves shift register untouched
// - forced value stays until next load
// - address, two fill bits, data msb first
// - address picks one of four registers
`timescale 1ns/1ps
`default_nettype none
module qdsl_top
  import qdsl_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        SERIAL_CLK_I,
  input  wire logic        SELECT_N_I,
  input  wire logic        SERIAL_DATA_IN_I,
  input  wire logic        LOAD_STROBE_N_I,
  input  wire logic        CLEAR_N_I,
  input  wire logic        CLEAR_LEVEL_SELECT_I,
  input  wire logic        CONV_READY_I,
  output logic      [11:0] CONV_A_O,
  output logic      [11:0] CONV_B_O,
  output logic      [11:0] CONV_C_O,
  output logic      [11:0] CONV_D_O,
  output logic             LOAD_VALID_O,
  output logic      [13:0] LOAD_WORD_O,
  output logic      [15:0] SHIFT_WORD_O
);
  localparam int NPIN = 6;

  logic [NPIN-1:0] meta_reg;
  logic [NPIN-1:0] sync_reg;
  logic            shclk_prev_reg;
  logic            load_prev_reg;
  logic [15:0]     shift_reg;
  logic [11:0]     conv_reg [NUM_CONV];
  logic            shclk_now;
  logic            shift_pulse;
  logic            load_fall;
  logic            load_low;
  logic            clear_act;
  logic            buf_in_ready;
  logic            buf_out_valid;
  logic [13:0]     buf_out_data;
  logic [13:0]     load_word;

  // pins pass two flops before use; stage one feeds only stage two
  // reset matches idle pins (clock low, clear level low) so no false edge follows
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      meta_reg <= SYNC_RESET;
      sync_reg <= SYNC_RESET;
    end
    else
    begin
      meta_reg <= {CLEAR_LEVEL_SELECT_I, CLEAR_N_I, LOAD_STROBE_N_I,
                   SELECT_N_I, SERIAL_CLK_I, SERIAL_DATA_IN_I};
      sync_reg <= meta_reg;
    end
  end

  // combined shift clock: either input rising while the other is low shifts one bit
  assign shclk_now   = sync_reg[1] | sync_reg[2];
  assign shift_pulse = shclk_now && !shclk_prev_reg;
  assign load_low    = !sync_reg[3];
  assign load_fall   = load_low && load_prev_reg;
  assign clear_act   = !sync_reg[4];
  assign load_word   = {shift_reg[ADDR_HI_POS:ADDR_LO_POS], shift_reg[DATA_MSB_POS:0]};

  // edge history for the combined clock and the load strobe
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      shclk_prev_reg <= 1'b1;
      load_prev_reg  <= 1'b1;
    end
    else
    begin
      shclk_prev_reg <= shclk_now;
      load_prev_reg  <= sync_reg[3];
    end
  end

  // shift register: first bit received ends up at the top after 16 shifts
  // clear never touches it so a later load can restore the old word
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      shift_reg <= SHIFT_RESET;
    else if (shift_pulse)
      shift_reg <= {shift_reg[14:0], sync_reg[0]};
  end

  // converter registers; clear wins, a low load keeps the addressed one transparent
  // hazard: host bits shifted while load is low leak straight through
  genvar g;
  generate
    for (g = 0; g < NUM_CONV; g++)
    begin : g_conv
      always_ff @(posedge CLK_I or posedge SYS_RST_I)
      begin
        if (SYS_RST_I)
          conv_reg[g] <= DATA_RESET;
        else if (clear_act)
          conv_reg[g] <= sync_reg[5] ? MIDSCALE : ZEROSCALE;
        else if (load_low && shift_reg[15:14] == 2'(g))
          conv_reg[g] <= shift_reg[DATA_MSB_POS:0];
        // otherwise held, including the clear value after release
      end
    end
  endgenerate

  // outputs registered straight from flops
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      CONV_A_O     <= DATA_RESET;
      CONV_B_O     <= DATA_RESET;
      CONV_C_O     <= DATA_RESET;
      CONV_D_O     <= DATA_RESET;
      SHIFT_WORD_O <= SHIFT_RESET;
    end
    else
    begin
      CONV_A_O     <= conv_reg[0];
      CONV_B_O     <= conv_reg[1];
      CONV_C_O     <= conv_reg[2];
      CONV_D_O     <= conv_reg[3];
      SHIFT_WORD_O <= shift_reg;
    end
  end

  // each load edge outside clear logs the word; a full buffer drops it rather than stall pins
  qdsl_buf #(
    .WIDTH (14)
  ) u_buf (
    .clk_i       (CLK_I),
    .rst_i       (SYS_RST_I),
    .in_valid_i  (load_fall && !clear_act),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (load_word),
    .out_valid_o (buf_out_valid),
    .out_ready_i (CONV_READY_I && !LOAD_VALID_O),
    .out_data_o  (buf_out_data)
  );

  // output stage: one word held until taken
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      LOAD_VALID_O <= 1'b0;
      LOAD_WORD_O  <= 14'h0000;
    end
    else if (LOAD_VALID_O && CONV_READY_I)
      LOAD_VALID_O <= 1'b0;
    else if (!LOAD_VALID_O && buf_out_valid && CONV_READY_I)
    begin
      LOAD_VALID_O <= 1'b1;
      LOAD_WORD_O  <= buf_out_data;
    end
  end

  a_shift_gated: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (sync_reg[2] && $past(sync_reg[2])) |=> $stable(shift_reg))
    else $error("shift register moved while select high");

  a_shift_order: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    shift_pulse |=> shift_reg == {$past(shift_reg[14:0]), $past(sync_reg[0])})
    else $error("shift did not append newest bit");

  // select must already have been low, else the combined clock was high before
  a_shift_edge: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (!sync_reg[2] && !$past(sync_reg[2]) && $rose(sync_reg[1])) |-> shift_pulse)
    else $error("clock rise with select low not shifted");

  a_or_clock: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (!sync_reg[1] && !$past(sync_reg[1]) && $rose(sync_reg[2])) |-> shift_pulse)
    else $error("select rise with clock low not shifted");

  a_clear_value: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    clear_act |=> conv_reg[2] == ($past(sync_reg[5]) ? MIDSCALE : ZEROSCALE))
    else $error("clear value wrong");

  a_clear_keep: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (clear_act && !shift_pulse) |=> $stable(shift_reg))
    else $error("clear disturbed shift register");

  a_clear_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (!clear_act && !load_low) |=> $stable(conv_reg[1]))
    else $error("register changed without load");

  a_load_route: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (load_fall && !clear_act && shift_reg[15:14] == 2'b11)
      |=> conv_reg[3] == $past(shift_reg[11:0]) && $stable(conv_reg[0]))
    else $error("load routed to wrong register");

  a_clear_wins: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (clear_act && load_low && !sync_reg[5]) |=> conv_reg[0] == ZEROSCALE)
    else $error("load overrode clear");

  a_load_follow: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (load_low && !clear_act && shift_reg[15:14] == 2'b00)
      |=> conv_reg[0] == $past(shift_reg[11:0]))
    else $error("low load did not copy word to register A");

  // a load edge with room in the buffer must leave a word waiting
  a_load_logged: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (load_fall && !clear_act && buf_in_ready) |=> buf_out_valid)
    else $error("load word not logged");
endmodule : qdsl_top
`default_nettype wire

/* File: verification/qdsl_host.sv */
// Purpose: host serial port model for the converter pins
// Assumes: drives on CLK_I rise; link half period is 10 system cycles
// Notes:   link clock stands still between frames, except while stray toggles it
`timescale 1ns/1ps
`default_nettype none
module qdsl_host
(
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      sel_n_o,
  output logic      sdi_o,
  output logic      ld_n_o
);
  // idle pins: clock low, select and load released
  initial
  begin
    sclk_o  = 1'b0;
    sel_n_o = 1'b1;
    sdi_o   = 1'b1;
    ld_n_o  = 1'b1;
  end
  // half of the 80 ns link period
  task automatic hp();
    repeat (10) @(posedge clk_i);
  endtask : hp
  // 20 bits msb first; by_sel clocks with select while clock stays low
  task automatic send(input logic [19:0] v, input bit by_sel);
    for (int i = 19; i >= 0; i--)
    begin
      sel_n_o <= 1'b0;
      sdi_o   <= v[i];
      hp();
      if (by_sel) sel_n_o <= 1'b1;
      else sclk_o <= 1'b1;
      hp();
      if (i > 0 && !by_sel) sclk_o <= 1'b0;
    end
    // deselect with clock high, or select already high when by_sel, so no false bit enters
    sel_n_o <= 1'b1;
    hp();
    sclk_o <= 1'b0;
    sdi_o  <= ~sdi_o;  // released line must not look stable
  endtask : send
  // no shifting while the strobe is low
  task automatic load();
    ld_n_o <= 1'b0;
    hp();
    ld_n_o <= 1'b1;
    hp();
  endtask : load
  // clock and data wiggle while deselected; n must be even
  task automatic stray(input int n);
    repeat (n)
    begin
      sdi_o  <= ~sdi_o;
      sclk_o <= ~sclk_o;
      hp();
    end
  endtask : stray
endmodule : qdsl_host
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: self-checking bench for serial load and clear
// Assumes: pins settle within 5 cycles; host waits 10 per edge
// Notes:   receiver stays stalled except while a word is taken or the emptied buffer is probed
`timescale 1ns/1ps
`default_nettype none
module tb;
  import qdsl_pkg::*;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        clr_n = 1'b1;
  logic        clear_level_select = 1'b0;
  logic        rdy   = 1'b0;
  logic        sclk, sel_n, serial_data_in, ld_n, lvalid;
  logic [11:0] conv [4];
  logic [13:0] lword;
  logic [15:0] sword, last_w;
  int          errors = 0;
  int          samples_checked = 0;
  // 250 MHz system clock
  always #2 clk = ~clk;
  qdsl_host host (.clk_i(clk), .sclk_o(sclk), .sel_n_o(sel_n), .sdi_o(serial_data_in), .ld_n_o(ld_n));
  qdsl_top dut (.CLK_I(clk), .SYS_RST_I(rst), .SERIAL_CLK_I(sclk), .SELECT_N_I(sel_n),
    .SERIAL_DATA_IN_I(serial_data_in), .LOAD_STROBE_N_I(ld_n), .CLEAR_N_I(clr_n),
    .CLEAR_LEVEL_SELECT_I(clear_level_select), .CONV_READY_I(rdy), .CONV_A_O(conv[0]),
    .CONV_B_O(conv[1]), .CONV_C_O(conv[2]), .CONV_D_O(conv[3]),
    .LOAD_VALID_O(lvalid), .LOAD_WORD_O(lword), .SHIFT_WORD_O(sword));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // take one logged word: valid only rises while ready is high, so ready
  // stands until valid is seen at a rising edge, and the word is taken there
  task automatic pop(input logic [13:0] exp);
    int n;
    n = 0;
    rdy <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (lvalid !== 1'b1 && n < 50);
    rdy <= 1'b0;
    chk("load valid", 16'h1, 16'(lvalid));
    chk("load word", 16'(exp), 16'(lword));
    @(posedge clk);
  endtask : pop
  // each address once, four stale lead bits pushed out
  task automatic t_load(input bit by_sel);
    logic [11:0] d [4];
    for (int a = 0; a < 4; a++)
    begin
      d[a] = 12'h9C3 + 12'(a) + (by_sel ? 12'h100 : 12'h000);
      last_w = {2'(a), 2'b11, d[a]};
      host.send({4'hF, last_w}, by_sel);
      chk("shift word", last_w, sword);
      host.load();
      chk("conv", 16'(d[a]), 16'(conv[a]));
      pop({last_w[15:14], d[a]});
    end
    for (int a = 0; a < 4; a++)
      chk("conv kept", 16'(d[a]), 16'(conv[a]));
  endtask : t_load
  // forced level, load ignored under clear, restore afterwards
  task automatic t_clear(input logic lvl);
    logic [11:0] v;
    v = lvl ? 12'h800 : 12'h000;
    clear_level_select <= lvl;
    clr_n <= 1'b0;
    host.hp();
    host.load();
    for (int a = 0; a < 4; a++)
      chk("conv cleared", 16'(v), 16'(conv[a]));
    chk("shift word", last_w, sword);
    clr_n <= 1'b1;
    host.hp();
    for (int a = 0; a < 4; a++)
      chk("conv held", 16'(v), 16'(conv[a]));
    host.load();
    chk("conv restored", 16'(last_w[11:0]), 16'(conv[3]));
    // only the load after release is logged; the one under clear is not
    pop({last_w[15:14], last_w[11:0]});
  endtask : t_clear
  // three loads into a stalled two-entry buffer
  task automatic t_buf();
    for (int a = 0; a < 3; a++)
    begin
      host.send({4'h0, 2'(a), 2'b00, 12'h3A0 + 12'(a)}, 1'b0);
      host.load();
    end
    chk("conv", 16'h03A2, 16'(conv[2]));
    pop({2'd0, 12'h3A0});
    pop({2'd1, 12'h3A1});
    // ready held high: a kept third word would show valid within two cycles
    rdy <= 1'b1;
    repeat (8)
    begin
      @(posedge clk);
      chk("no third word", 16'h0, 16'(lvalid));
    end
    rdy <= 1'b0;
    @(posedge clk);
  endtask : t_buf
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  // main sequence after five reset cycles
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_load(1'b0);
    t_load(1'b1);
    host.stray(8);
    chk("shift word", last_w, sword);
    t_clear(1'b1);
    t_clear(1'b0);
    t_buf();
    finish_test();
  end
  // whole run is about 5k cycles; stop a hang at 25k, well inside the budget
  initial
  begin
    #100000;
    errors++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
